// ===== codec_input_ctrl_pkg.sv
// Constants for the audio input analogue control register bank.
// Assumes a byte-addressed AXI4-Lite bus with one 32-bit word per register.

package codec_input_ctrl_pkg;

  // --------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_ANALOG_POWER  = 8'h02;
  localparam logic [7:0] IDX_INPUT_PATH    = 8'h03;
  localparam logic [7:0] IDX_AMP_CONNECT   = 8'h28;
  localparam logic [7:0] IDX_MIC_LEVEL     = 8'h3a;
  localparam logic [7:0] IDX_DETECT_CTRL   = 8'h40;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h41;
  localparam logic [7:0] IDX_IRQ_CLEAR     = 8'h42;
  localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h43;
  localparam logic [7:0] IDX_PIN_BIAS      = 8'h44;

  localparam int unsigned REG_W            = 16;
  localparam int unsigned IDX_LSB          = 2;
  localparam int unsigned IDX_MSB          = 9;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int unsigned CODEC_MASTER_ENABLE_BIT    = 15;
  localparam int unsigned MIC_BIAS_ENA_BIT = 4;
  localparam int unsigned DIVIDER_MSB      = 2;
  localparam int unsigned DIVIDER_LSB      = 1;
  localparam int unsigned BIAS_ENA_BIT     = 0;
  localparam int unsigned LEFT_AMP_B_BIT   = 7;
  localparam int unsigned LEFT_AMP_A_BIT   = 6;
  localparam int unsigned RIGHT_AMP_B_BIT  = 5;
  localparam int unsigned RIGHT_AMP_A_BIT  = 4;
  localparam int unsigned MIC_LEVEL_BIT    = 0;
  localparam int unsigned DETECT_ENA_BIT   = 0;
  localparam int unsigned NORMAL_THR_LSB   = 4;
  localparam int unsigned SHORT_THR_LSB    = 8;
  localparam int unsigned THR_MAX_W        = 4;
  localparam int unsigned PIN_BIAS_BIT     = 0;
  localparam int unsigned IRQ_NORMAL_BIT   = 0;
  localparam int unsigned IRQ_SHORT_BIT    = 1;
  localparam int unsigned IRQ_W            = 2;
  localparam int unsigned CONNECT_W        = 8;

  // Connection bits of the amplifier input connect register
  localparam int unsigned LEFT_PIN4_TO_AMP_B_NONINV_BIT  = 7;
  localparam int unsigned LEFT_PIN3_TO_AMP_B_INV_BIT     = 6;
  localparam int unsigned LEFT_PIN2_TO_AMP_A_NONINV_BIT  = 5;
  localparam int unsigned LEFT_PIN1_TO_AMP_A_INV_BIT     = 4;
  localparam int unsigned RIGHT_PIN4_TO_AMP_B_NONINV_BIT = 3;
  localparam int unsigned RIGHT_PIN3_TO_AMP_B_INV_BIT    = 2;
  localparam int unsigned RIGHT_PIN2_TO_AMP_A_NONINV_BIT = 1;
  localparam int unsigned RIGHT_PIN1_TO_AMP_A_INV_BIT    = 0;

  // --------------------------------------------------------------------------
  // Writable masks and reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] ANALOG_POWER_MASK = 16'h8017;
  localparam logic [15:0] INPUT_PATH_MASK   = 16'h00f0;
  localparam logic [15:0] AMP_CONNECT_MASK  = 16'h00ff;
  localparam logic [15:0] MIC_LEVEL_MASK    = 16'h0001;
  localparam logic [15:0] PIN_BIAS_MASK     = 16'h0001;
  localparam logic [15:0] REG_RESET         = 16'h0000;

  // --------------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DIV_OFF     = 2'h0,
    DIV_NORMAL  = 2'h1,
    DIV_STANDBY = 2'h2,
    DIV_FAST    = 2'h3
  } divider_mode_type;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : codec_input_ctrl_pkg

// ===== level_sync.sv
// Two-flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from outside the core_clk domain.

`timescale 1ns/1ns

module level_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;

  // --------------------------------------------------------------------------
  // Synchroniser chain
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule : level_sync

// ===== audio_input_analog_control_regs.sv
// Control register bank for the analogue front end of the audio input path.
// Assumes an AXI4-Lite master on core_clk, detector levels from analogue
// comparators (asynchronous), and input enables from GPIO logic on core_clk.
//
// The AXI4-Lite interface to the registers is this design's own decision.

`timescale 1ns/1ns

// Notes on behaviour
// - Four amplifier enables sit at bits 7..4 of the input path register, reset 0.
// - Bits 2:1 of analogue power pick the divider: off, normal, standby, fast start.
// - Bit 0 of analogue power switches the bias for all analogue functions, reset off.
// - Bit 4 of analogue power turns the mic bias output on, reset off (high impedance).
// - Bit 0 of the mic bias level register picks 0.9 (0) or 0.65 (1) of the supply.
// - With detect enabled, a crossed current threshold raises an interrupt and an output.
// - Eight connect bits 7..0, reset 0, each link one pin to one amplifier input.
// - Clearing connect bits isolates that path, giving its greatest attenuation.
// - Pins that are neither analogue nor GPIO inputs may be biased to mid rail.
// - While the master codec enable bit 15 is 0 all registers hold their defaults.
module audio_input_analog_control_regs
  import codec_input_ctrl_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned THR_W  = 3
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  normalCurrentExceeded,
  input  wire logic                  shortCurrentExceeded,
  input  wire logic [CONNECT_W-1:0]  gpioInputEnable,
  output logic                       codecMasterEnable,
  output logic                       leftAmpAEnable,
  output logic                       leftAmpBEnable,
  output logic                       rightAmpAEnable,
  output logic                       rightAmpBEnable,
  output divider_mode_type           midRailDividerSelect,
  output logic                       analogBiasEnable,
  output logic                       micBiasEnable,
  output logic                       micBiasLevelSelect,
  output logic                       micCurrentDetectEnable,
  output logic [THR_W-1:0]           micCurrentNormalThreshold,
  output logic [THR_W-1:0]           micCurrentShortThreshold,
  output logic [CONNECT_W-1:0]       ampInputConnect,
  output logic [CONNECT_W-1:0]       pinMidRailBias,
  output logic                       micCurrentDetectOut,
  output logic                       irq
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (ADDR_W < IDX_MSB + 2) begin : gAddrCheck
    $error("ADDR_W too small for the register map");
  end
  if (THR_W < 1 || THR_W > THR_MAX_W) begin : gThrCheck
    $error("THR_W must lie between 1 and 4");
  end

  localparam logic [15:0] NORMAL_THR_MASK = 16'(((1 << THR_W) - 1) << NORMAL_THR_LSB);
  localparam logic [15:0] SHORT_THR_MASK  = 16'(((1 << THR_W) - 1) << SHORT_THR_LSB);
  localparam logic [15:0] DETECT_MASK     = 16'(NORMAL_THR_MASK | SHORT_THR_MASK | 16'h0001);
  localparam logic [15:0] IRQ_MASK        = 16'((1 << IRQ_W) - 1);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [15:0]       analogPower_r;
  logic [15:0]       inputPath_r;
  logic [15:0]       ampConnect_r;
  logic [15:0]       micLevel_r;
  logic [15:0]       detectCtrl_r;
  logic [15:0]       pinBias_r;
  logic [IRQ_W-1:0]  irqStatus_r;
  logic [IRQ_W-1:0]  irqEnable_r;
  logic [15:0]       analogPower_nxt;
  logic [15:0]       inputPath_nxt;
  logic [15:0]       ampConnect_nxt;
  logic [15:0]       micLevel_nxt;
  logic [15:0]       detectCtrl_nxt;
  logic [15:0]       pinBias_nxt;
  logic [IRQ_W-1:0]  irqStatus_nxt;
  logic [IRQ_W-1:0]  irqEnable_nxt;

  // Bus holding state
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;

  // --------------------------------------------------------------------------
  // Byte-lane merge of a write into a 16-bit register
  // --------------------------------------------------------------------------
  function automatic logic [15:0] mergeWrite(input logic [15:0] cur,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb,
                                             input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = cur;
    if (strb[0]) begin
      lanes[7:0] = data[7:0];
    end
    if (strb[1]) begin
      lanes[15:8] = data[15:8];
    end
    mergeWrite = lanes & mask;
  endfunction : mergeWrite

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  wire [7:0] wIdx       = awAddr_r[IDX_MSB:IDX_LSB];
  wire       wAddrOk    = (awAddr_r[1:0] == 2'h0) && ((awAddr_r >> (IDX_MSB + 1)) == '0);
  wire       doWrite    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire       hitPower   = doWrite & wAddrOk & (wIdx == IDX_ANALOG_POWER);
  wire       hitPath    = doWrite & wAddrOk & (wIdx == IDX_INPUT_PATH);
  wire       hitConnect = doWrite & wAddrOk & (wIdx == IDX_AMP_CONNECT);
  wire       hitLevel   = doWrite & wAddrOk & (wIdx == IDX_MIC_LEVEL);
  wire       hitDetect  = doWrite & wAddrOk & (wIdx == IDX_DETECT_CTRL);
  wire       hitStatus  = doWrite & wAddrOk & (wIdx == IDX_IRQ_STATUS);
  wire       hitClear   = doWrite & wAddrOk & (wIdx == IDX_IRQ_CLEAR);
  wire       hitEnable  = doWrite & wAddrOk & (wIdx == IDX_IRQ_ENABLE);
  wire       hitPinBias = doWrite & wAddrOk & (wIdx == IDX_PIN_BIAS);
  wire       wMapped    = hitPower | hitPath | hitConnect | hitLevel | hitDetect |
                          hitStatus | hitClear | hitEnable | hitPinBias;

  wire [15:0] powerMerged = mergeWrite(analogPower_r, wData_r, wStrb_r, ANALOG_POWER_MASK);
  wire [15:0] clearMerged = mergeWrite(REG_RESET, wData_r, wStrb_r, IRQ_MASK);

  // Codec disabled, or being disabled by this write, forces the others to default
  wire holdDefaults = ~analogPower_nxt[CODEC_MASTER_ENABLE_BIT];

  // --------------------------------------------------------------------------
  // Next values of the control registers
  // --------------------------------------------------------------------------
  assign analogPower_nxt = !hitPower                  ? analogPower_r :
                           powerMerged[CODEC_MASTER_ENABLE_BIT] ? powerMerged   :
                                                        REG_RESET;
  assign inputPath_nxt   = holdDefaults ? REG_RESET :
                           hitPath      ? mergeWrite(inputPath_r, wData_r, wStrb_r,
                                                     INPUT_PATH_MASK) :
                                          inputPath_r;
  assign ampConnect_nxt  = holdDefaults ? REG_RESET :
                           hitConnect   ? mergeWrite(ampConnect_r, wData_r, wStrb_r,
                                                     AMP_CONNECT_MASK) :
                                          ampConnect_r;
  assign micLevel_nxt    = holdDefaults ? REG_RESET :
                           hitLevel     ? mergeWrite(micLevel_r, wData_r, wStrb_r,
                                                     MIC_LEVEL_MASK) :
                                          micLevel_r;
  assign detectCtrl_nxt  = holdDefaults ? REG_RESET :
                           hitDetect    ? mergeWrite(detectCtrl_r, wData_r, wStrb_r,
                                                     DETECT_MASK) :
                                          detectCtrl_r;
  assign pinBias_nxt     = holdDefaults ? REG_RESET :
                           hitPinBias   ? mergeWrite(pinBias_r, wData_r, wStrb_r,
                                                     PIN_BIAS_MASK) :
                                          pinBias_r;
  assign irqEnable_nxt   = holdDefaults ? IRQ_W'(REG_RESET) :
                           hitEnable    ? IRQ_W'(mergeWrite(16'(irqEnable_r), wData_r,
                                                            wStrb_r, IRQ_MASK)) :
                                          irqEnable_r;

  // --------------------------------------------------------------------------
  // Current detect events
  // --------------------------------------------------------------------------
  logic [IRQ_W-1:0] detectSync;

  level_sync #(
    .W (IRQ_W)
  ) uDetectSync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({shortCurrentExceeded, normalCurrentExceeded}),
    .syncOut  (detectSync)
  );

  wire              detectOn    = detectCtrl_r[DETECT_ENA_BIT];
  wire [IRQ_W-1:0]  detectEvent = detectSync & {IRQ_W{detectOn}};
  wire [IRQ_W-1:0]  clearBits   = hitClear ? clearMerged[IRQ_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  assign irqStatus_nxt = holdDefaults ? '0 : (irqStatus_r & ~clearBits) | detectEvent;

  // --------------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------------
  wire [7:0]  rIdx    = s_axi_araddr[IDX_MSB:IDX_LSB];
  wire        rAddrOk = (s_axi_araddr[1:0] == 2'h0) &&
                        ((s_axi_araddr >> (IDX_MSB + 1)) == '0);
  wire [15:0] rWord   = (rIdx == IDX_ANALOG_POWER) ? analogPower_r :
                        (rIdx == IDX_INPUT_PATH)   ? inputPath_r   :
                        (rIdx == IDX_AMP_CONNECT)  ? ampConnect_r  :
                        (rIdx == IDX_MIC_LEVEL)    ? micLevel_r    :
                        (rIdx == IDX_DETECT_CTRL)  ? detectCtrl_r  :
                        (rIdx == IDX_IRQ_STATUS)   ? 16'(irqStatus_r) :
                        (rIdx == IDX_IRQ_ENABLE)   ? 16'(irqEnable_r) :
                        (rIdx == IDX_PIN_BIAS)     ? pinBias_r     :
                                                     REG_RESET;
  wire        rMapped = rAddrOk &&
                        ((rIdx == IDX_ANALOG_POWER) || (rIdx == IDX_INPUT_PATH)  ||
                         (rIdx == IDX_AMP_CONNECT)  || (rIdx == IDX_MIC_LEVEL)   ||
                         (rIdx == IDX_DETECT_CTRL)  || (rIdx == IDX_IRQ_STATUS)  ||
                         (rIdx == IDX_IRQ_CLEAR)    || (rIdx == IDX_IRQ_ENABLE)  ||
                         (rIdx == IDX_PIN_BIAS));
  wire        arTake  = s_axi_arvalid & s_axi_arready;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channels
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      awAddr_r      <= '0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awAddr_r      <= s_axi_awaddr;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wData_r      <= '0;
      wStrb_r      <= '0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wData_r      <= s_axi_wdata;
      wStrb_r      <= s_axi_wstrb;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wMapped && !hitStatus) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channels
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rWord};
      s_axi_rresp   <= rMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register update
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      analogPower_r <= REG_RESET;
      inputPath_r   <= REG_RESET;
      ampConnect_r  <= REG_RESET;
      micLevel_r    <= REG_RESET;
      detectCtrl_r  <= REG_RESET;
      pinBias_r     <= REG_RESET;
      irqStatus_r   <= '0;
      irqEnable_r   <= '0;
    end else begin
      analogPower_r <= analogPower_nxt;
      inputPath_r   <= inputPath_nxt;
      ampConnect_r  <= ampConnect_nxt;
      micLevel_r    <= micLevel_nxt;
      detectCtrl_r  <= detectCtrl_nxt;
      pinBias_r     <= pinBias_nxt;
      irqStatus_r   <= irqStatus_nxt;
      irqEnable_r   <= irqEnable_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Analogue control outputs
  // --------------------------------------------------------------------------
  assign codecMasterEnable         = analogPower_r[CODEC_MASTER_ENABLE_BIT];
  assign leftAmpAEnable            = inputPath_r[LEFT_AMP_A_BIT];
  assign leftAmpBEnable            = inputPath_r[LEFT_AMP_B_BIT];
  assign rightAmpAEnable           = inputPath_r[RIGHT_AMP_A_BIT];
  assign rightAmpBEnable           = inputPath_r[RIGHT_AMP_B_BIT];
  assign midRailDividerSelect      =
    divider_mode_type'(analogPower_r[DIVIDER_MSB:DIVIDER_LSB]);
  assign analogBiasEnable          = analogPower_r[BIAS_ENA_BIT];
  assign micBiasEnable             = analogPower_r[MIC_BIAS_ENA_BIT];
  assign micBiasLevelSelect        = micLevel_r[MIC_LEVEL_BIT];
  assign micCurrentDetectEnable    = detectOn;
  assign micCurrentNormalThreshold = detectCtrl_r[NORMAL_THR_LSB +: THR_W];
  assign micCurrentShortThreshold  = detectCtrl_r[SHORT_THR_LSB +: THR_W];
  // A cleared bit opens its switch and isolates that path
  assign ampInputConnect           = ampConnect_r[CONNECT_W-1:0];

  // --------------------------------------------------------------------------
  // Pin bias, detect output and interrupt
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < CONNECT_W; i++) begin : gPinBias
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pinMidRailBias[i] <= 1'b0;
      end else begin
        pinMidRailBias[i] <= pinBias_r[PIN_BIAS_BIT] & ~ampConnect_r[i] &
                             ~gpioInputEnable[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      micCurrentDetectOut <= 1'b0;
      irq                 <= 1'b0;
    end else begin
      micCurrentDetectOut <= |detectEvent;
      irq                 <= |(irqStatus_r & irqEnable_r);
    end
  end

endmodule : audio_input_analog_control_regs

// ===== aiac_chk.sv
// Assertions on the ports of the analogue input control bank.
// Assumes it is bound onto audio_input_analog_control_regs.
`timescale 1ns/1ns
module aiac_chk import codec_input_ctrl_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        codecMasterEnable,
  input wire logic        leftAmpAEnable,
  input wire logic        micBiasEnable,
  input wire logic [7:0]  ampInputConnect,
  input wire logic [7:0]  pinMidRailBias,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  hold_dflt_a: assert property (!codecMasterEnable |-> !leftAmpAEnable && !micBiasEnable
    && ampInputConnect == 8'h00) else $error("setting kept while disabled");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer not held");
  wr_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer not held");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  wr_only_a: assert property ($changed({leftAmpAEnable, micBiasEnable, ampInputConnect})
    |-> $rose(s_axi_bvalid)) else $error("control changed without write");
  irq_gate_a: assert property (irq |-> $past(codecMasterEnable))
    else $error("interrupt while disabled");
  bias_free_a: assert property (pinMidRailBias != 8'h00
    |-> (pinMidRailBias & $past(ampInputConnect)) == 8'h00) else $error("connected pin biased");
  cover property ($rose(irq));
  cover property ($fell(codecMasterEnable));
  cover property (pinMidRailBias != 8'h00);
endmodule : aiac_chk
bind audio_input_analog_control_regs aiac_chk chk (.core_clk, .rst, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .codecMasterEnable,
  .leftAmpAEnable, .micBiasEnable, .ampInputConnect, .pinMidRailBias, .irq);

// ===== audio_input_analog_control_regs_tb_top.sv
// Self-checking bench of the analogue input control bank.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ns
module audio_input_analog_control_regs_tb_top import codec_input_ctrl_pkg::*;;
  logic core_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, nrm = 1'b0;
  logic [11:0] aw = 12'h000, ar = 12'h000;
  logic [31:0] wd = 32'h0, rdata;
  logic [7:0] gpio = 8'h00, conn, pmb;
  logic [1:0] bresp, rresp;
  logic awr, wRdy, bv, arr, rv, cme, laA, laB, raA, raB, abe, mbe, mls, mcdo, irq;
  divider_mode_type div;
  logic brdy = 1'b1, rrdy = 1'b1, mcde;
  logic [2:0] thrN, thrS;
  int miscompares = 0, nCompared = 0;
  localparam logic [11:0] ADR [4] = '{12'h008, 12'h00c, 12'h0a0, 12'h0e8};
  always #2 core_clk = ~core_clk;
  audio_input_analog_control_regs dut (.core_clk, .rst, .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wRdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .normalCurrentExceeded(nrm),
    .shortCurrentExceeded(nrm), .gpioInputEnable(gpio), .codecMasterEnable(cme),
    .leftAmpAEnable(laA), .leftAmpBEnable(laB), .rightAmpAEnable(raA), .rightAmpBEnable(raB),
    .midRailDividerSelect(div), .analogBiasEnable(abe), .micBiasEnable(mbe),
    .micBiasLevelSelect(mls), .micCurrentDetectEnable(mcde), .micCurrentNormalThreshold(thrN),
    .micCurrentShortThreshold(thrS), .ampInputConnect(conn), .pinMidRailBias(pmb),
    .micCurrentDetectOut(mcdo), .irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge core_clk);
    aw <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!done) begin
      @(negedge core_clk);
      ta = awr;
      tw = wRdy;
      done = bv;
      if (bv) check(32'(bresp), 32'(er));
      @(posedge core_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    if (!brdy) begin
      brdy <= 1'b1;
      @(posedge core_clk);
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge core_clk);
    ar <= a;
    arv <= 1'b1;
    do @(negedge core_clk); while (!arr);
    @(posedge core_clk);
    arv <= 1'b0;
    do @(negedge core_clk); while (!rv);
    check(rdata, {16'h0000, e});
    check(32'(rresp), 32'(er));
    @(posedge core_clk);
    if (!rrdy) begin
      rrdy <= 1'b1;
      @(posedge core_clk);
    end
  endtask : rd
  task automatic complete_run;
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ADR[i]) rd(ADR[i], 16'h0000, RESP_OKAY);
    wr(12'h008, 16'h7fff, RESP_OKAY);
    rd(12'h008, 16'h0000, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(12'h008, 16'h8011 | 16'(i << 1), RESP_OKAY);
      check(32'(div), 32'(i));
    end
    check(32'({abe, mbe}), 32'h3);
    wr(12'h00c, 16'hffff, RESP_OKAY);
    rd(12'h00c, 16'h00f0, RESP_OKAY);
    wr(12'h00c, 16'h0050, RESP_OKAY);
    check(32'({laB, laA, raB, raA}), 32'h5);
    wr(12'h0a0, 16'h0055, RESP_OKAY);
    check(32'(conn), 32'h55);
    wr(12'h0a0, 16'h00f0, RESP_OKAY);
    check(32'(conn), 32'hf0);
    wr(12'h0a0, 16'h01a5, RESP_OKAY);
    check(32'(conn), 32'ha5);
    wr(12'h110, 16'h0001, RESP_OKAY);
    gpio <= 8'h0f;
    repeat (3) @(negedge core_clk);
    check(32'(pmb), 32'h50);
    wr(12'h0e8, 16'hffff, RESP_OKAY);
    rrdy <= 1'b0;
    rd(12'h0e8, 16'h0001, RESP_OKAY);
    check(32'(mls), 32'h1);
    rd(12'h004, 16'h0000, RESP_SLVERR);
    brdy <= 1'b0;
    wr(12'h004, 16'hffff, RESP_SLVERR);
    $display("register test done");
    wr(12'h100, 16'h0351, RESP_OKAY);
    check(32'({thrS, thrN, mcde}), 32'h3b);
    wr(12'h10c, 16'h0003, RESP_OKAY);
    nrm <= 1'b1;
    repeat (6) @(negedge core_clk);
    check(32'({mcdo, irq}), 32'h3);
    @(posedge core_clk);
    nrm <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(12'h104, 16'h0003, RESP_OKAY);
    wr(12'h10c, 16'h0000, RESP_OKAY);
    repeat (2) @(negedge core_clk);
    check(32'(irq), 32'h0);
    wr(12'h108, 16'h0001, RESP_OKAY);
    rd(12'h104, 16'h0002, RESP_OKAY);
    $display("interrupt test done");
    wr(12'h008, 16'h0000, RESP_OKAY);
    rd(12'h0a0, 16'h0000, RESP_OKAY);
    $display("disable test done");
    complete_run();
  end
  initial begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule : audio_input_analog_control_regs_tb_top
